// ==== mfpm_pkg.sv ====
// Constants, carrier types and register map of the multifunction status pin selector
// What this block does
// - Code bit 7 set drives pin as output
// - 0x80 low, 0x81 high, 0x82 clock/32
// - 0x83 one short strobe per watchdog expiry
// - 0x84-0x86 mirror memory write/read/fault status
// - 0x88 multiplier lock, 0x89 multiplier stable
// - 0x8B/0x8C per-channel digital, analog, multiplier lock AND
// - 0x8A both channels fully locked
// - 0x90 OR of interrupts; 0x91-0x93 single lines
// - 0xA0-0xA3 reference fault flags
// - 0xA8-0xAB reference valid flags
// - 0xB0-0xB3 reference active in either channel
// - 0xC0-0xC3 channel 0 lock and calibration status
// - 0xC5-0xC7 channel 0 free run, holdover, switchover
// - 0xC8-0xCB channel 0 tuning history, clamp, slew
// - 0xCC channel 0 distribution sync pulse event
// - 0xD0-0xDC same indications for channel 1
// - Bit 7 clear: pin is a high-impedance input
package mfpm_pkg;

	// Timing: strobe is a least time, so it rounds up
	localparam int CLK_PERIOD_NS = 50;
	localparam int STROBE_NS = 40;
	localparam int STROBE_CYC_RAW = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
	localparam int STROBE_W = 4;
	localparam int DIV_RATIO = 32;
	localparam int DIV_W = $clog2(DIV_RATIO);

	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_FUNC = 8'h00;
	localparam logic [7:0] ADDR_PIN = 8'h04;
	localparam logic [7:0] ADDR_ISTAT = 8'h08;
	localparam logic [7:0] ADDR_ICLR = 8'h0c;
	localparam logic [7:0] ADDR_IEN = 8'h10;

	// Reset values and field positions
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam int DIR_BIT = 7;
	localparam int PIN_OUT_BIT = 0;
	localparam int PIN_IN_BIT = 1;
	localparam int PIN_OE_BIT = 2;
	localparam int IRQ_W = 3;
	localparam int IRQ_WDOG_BIT = 0;
	localparam int IRQ_PIN_IN_BIT = 1;
	localparam int IRQ_PIN_OUT_BIT = 2;
	localparam logic [IRQ_W-1:0] IEN_RESET = 3'h0;

	// Exact output function codes
	localparam logic [7:0] FN_LOW = 8'h80;
	localparam logic [7:0] FN_HIGH = 8'h81;
	localparam logic [7:0] FN_DIV = 8'h82;
	localparam logic [7:0] FN_WDOG = 8'h83;
	localparam logic [7:0] FN_MEM_WR = 8'h84;
	localparam logic [7:0] FN_MEM_RD = 8'h85;
	localparam logic [7:0] FN_MEM_FAULT = 8'h86;
	localparam logic [7:0] FN_SM_LOCK = 8'h88;
	localparam logic [7:0] FN_SM_STABLE = 8'h89;
	localparam logic [7:0] FN_ALL_LOCK = 8'h8a;
	localparam logic [7:0] FN_CH0_LOCK = 8'h8b;
	localparam logic [7:0] FN_CH1_LOCK = 8'h8c;
	localparam logic [7:0] FN_IRQ_ANY = 8'h90;
	localparam logic [7:0] FN_IRQ_COMMON = 8'h91;
	localparam logic [7:0] FN_IRQ_CH0 = 8'h92;
	localparam logic [7:0] FN_IRQ_CH1 = 8'h93;

	// Grouped codes: reference groups match code[7:2], channel groups code[7:4]
	localparam logic [5:0] FN_REF_FAULT_GRP = 6'h28;
	localparam logic [5:0] FN_REF_VALID_GRP = 6'h2a;
	localparam logic [5:0] FN_REF_ACT_GRP = 6'h2c;
	localparam logic [3:0] FN_CH0_GRP = 4'hc;
	localparam logic [3:0] FN_CH1_GRP = 4'hd;

	localparam int NUM_CHAN = 2;
	localparam int NUM_REF = 4;
	localparam int CHAN_SRC_W = 13;

	// Per-channel status; bit position equals the low nibble of its code
	typedef struct packed {
		logic sync_pulse;
		logic slew_limited;
		logic tw_clamp;
		logic tw_hist_upd;
		logic tw_hist_avail;
		logic switchover;
		logic holdover;
		logic free_run;
		logic active;
		logic an_cal;
		logic an_lock;
		logic freq_lock;
		logic phase_lock;
	} mfpm_chan_t;

	// Per-reference status
	typedef struct packed {
		logic active_ch1;
		logic active_ch0;
		logic valid;
		logic fault;
	} mfpm_ref_t;

	// All live status that the pin may show
	typedef struct packed {
		logic [NUM_CHAN-1:0] irq_chan;
		logic irq_common;
		mfpm_chan_t [NUM_CHAN-1:0] chan;
		mfpm_ref_t [NUM_REF-1:0] refs;
		logic sm_stable;
		logic sm_lock;
		logic mem_fault;
		logic mem_rd_busy;
		logic mem_wr_busy;
	} mfpm_stat_t;

endpackage

// ==== mfpm_top.sv ====
// Multifunction status pin selector with its APB register slave
`timescale 1ns/1ps
module mfpm_top
	import mfpm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mfpm_stat_t stat,
	input wire logic wdog_expire,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic irq
);

	logic [7:0] func_q, func_d;
	logic [IRQ_W-1:0] ien_q, ien_d;
	logic [IRQ_W-1:0] ists_q, ists_d;
	logic [31:0] rdata_q, rdata_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [STROBE_W-1:0] strobe_q, strobe_d;
	logic pin_q, pin_d;
	logic oe_q, oe_d;
	logic in_meta_q, in_sync_q, in_prev_q;
	logic sel_src;
	logic setup, access, wr_en, mapped;
	logic [NUM_CHAN-1:0] chan_lock;
	logic [NUM_CHAN-1:0] chan_pick;
	logic [IRQ_W-1:0] ev_set, ev_clr;

	// APB decode; zero wait states, so the access phase always completes
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_en = access & pwrite;
	assign mapped = (paddr == ADDR_FUNC) | (paddr == ADDR_PIN) | (paddr == ADDR_ISTAT)
		| (paddr == ADDR_ICLR) | (paddr == ADDR_IEN);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = rdata_q;

	// Per-channel lock product and status pick, one copy per channel
	for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
		logic [CHAN_SRC_W-1:0] src;
		assign src = stat.chan[ch];
		assign chan_lock[ch] = stat.chan[ch].phase_lock & stat.chan[ch].an_lock
			& stat.sm_lock;
		// Codes past the last channel entry fall to low
		assign chan_pick[ch] = (32'(func_q[3:0]) < CHAN_SRC_W) ? src[func_q[3:0]]
			: 1'b0;
	end

	// Source selection from the function code
	always_comb begin
		sel_src = 1'b0;
		case (func_q)
			FN_LOW: sel_src = 1'b0;
			FN_HIGH: sel_src = 1'b1;
			FN_DIV: sel_src = div_q[DIV_W-1];
			FN_WDOG: sel_src = (strobe_q != '0);
			FN_MEM_WR: sel_src = stat.mem_wr_busy;
			FN_MEM_RD: sel_src = stat.mem_rd_busy;
			FN_MEM_FAULT: sel_src = stat.mem_fault;
			FN_SM_LOCK: sel_src = stat.sm_lock;
			FN_SM_STABLE: sel_src = stat.sm_stable;
			FN_ALL_LOCK: sel_src = &chan_lock;
			FN_CH0_LOCK: sel_src = chan_lock[0];
			FN_CH1_LOCK: sel_src = chan_lock[1];
			FN_IRQ_ANY: sel_src = stat.irq_common | (|stat.irq_chan);
			FN_IRQ_COMMON: sel_src = stat.irq_common;
			FN_IRQ_CH0: sel_src = stat.irq_chan[0];
			FN_IRQ_CH1: sel_src = stat.irq_chan[1];
			default: begin
				if (func_q[7:2] == FN_REF_FAULT_GRP) begin
					sel_src = stat.refs[func_q[1:0]].fault;
				end else if (func_q[7:2] == FN_REF_VALID_GRP) begin
					sel_src = stat.refs[func_q[1:0]].valid;
				end else if (func_q[7:2] == FN_REF_ACT_GRP) begin
					sel_src = stat.refs[func_q[1:0]].active_ch0
						| stat.refs[func_q[1:0]].active_ch1;
				end else if (func_q[7:4] == FN_CH0_GRP) begin
					sel_src = chan_pick[0];
				end else if (func_q[7:4] == FN_CH1_GRP) begin
					sel_src = chan_pick[1];
				end else begin
					sel_src = 1'b0;
				end
			end
		endcase
	end

	// Pin drive: registered so the pin never glitches while the mux settles
	always_comb begin
		oe_d = func_q[DIR_BIT];
		pin_d = func_q[DIR_BIT] ? sel_src : 1'b0;
	end

	// Divider and watchdog strobe timing
	always_comb begin
		div_d = div_q + 1'b1;
		if (wdog_expire) begin
			strobe_d = STROBE_W'(STROBE_CYC);
		end else if (strobe_q != '0) begin
			strobe_d = strobe_q - 1'b1;
		end else begin
			strobe_d = strobe_q;
		end
	end

	// Events set sticky bits; a set in the clear cycle wins
	always_comb begin
		ev_set = '0;
		ev_set[IRQ_WDOG_BIT] = wdog_expire;
		ev_set[IRQ_PIN_IN_BIT] = ~func_q[DIR_BIT] & in_sync_q & ~in_prev_q;
		ev_set[IRQ_PIN_OUT_BIT] = oe_q & pin_d & ~pin_q;
		ev_clr = (wr_en && paddr == ADDR_ICLR) ? pwdata[IRQ_W-1:0] : '0;
		ists_d = (ists_q & ~ev_clr) | ev_set;
	end

	// Register writes and the read data captured in the setup phase
	always_comb begin
		func_d = func_q;
		ien_d = ien_q;
		if (wr_en && paddr == ADDR_FUNC) begin
			func_d = pwdata[7:0];
		end
		if (wr_en && paddr == ADDR_IEN) begin
			ien_d = pwdata[IRQ_W-1:0];
		end
		rdata_d = rdata_q;
		if (setup) begin
			rdata_d = '0;
			if (!pwrite) begin
				case (paddr)
					ADDR_FUNC: rdata_d[7:0] = func_q;
					ADDR_PIN: begin
						rdata_d[PIN_OUT_BIT] = pin_q;
						rdata_d[PIN_IN_BIT] = in_sync_q;
						rdata_d[PIN_OE_BIT] = oe_q;
					end
					ADDR_ISTAT: rdata_d[IRQ_W-1:0] = ists_q;
					ADDR_IEN: rdata_d[IRQ_W-1:0] = ien_q;
					default: rdata_d = '0;
				endcase
			end
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_q <= FUNC_RESET;
			ien_q <= IEN_RESET;
			ists_q <= '0;
			rdata_q <= '0;
			div_q <= '0;
			strobe_q <= '0;
			pin_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			func_q <= func_d;
			ien_q <= ien_d;
			ists_q <= ists_d;
			rdata_q <= rdata_d;
			div_q <= div_d;
			strobe_q <= strobe_d;
			pin_q <= pin_d;
			oe_q <= oe_d;
		end
	end

	// Pin input synchroniser; only the second and third stages are looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_meta_q <= 1'b0;
			in_sync_q <= 1'b0;
			in_prev_q <= 1'b0;
		end else begin
			in_meta_q <= pin_in;
			in_sync_q <= in_meta_q;
			in_prev_q <= in_sync_q;
		end
	end

	assign pin_out = pin_q;
	assign pin_oe = oe_q;
	assign irq = |(ists_q & ien_q);

	// Divider check helper: age of the divider code and length of each steady pin run.
	// The pin lags the code by one edge, so a run counts only after two divider samples.
	logic [1:0] div_age_q, div_age_d;
	logic [DIV_W:0] run_q, run_d;
	logic run_ok_q, run_ok_d;
	logic pin_prev_q;
	logic div_live, div_edge;
	always_comb begin
		div_live = (div_age_q == 2'h2);
		div_edge = div_live & (pin_out != pin_prev_q);
		div_age_d = 2'h0;
		if (func_q == FN_DIV) begin
			div_age_d = div_live ? div_age_q : div_age_q + 2'h1;
		end
		run_d = '0;
		run_ok_d = 1'b0;
		if (div_edge) begin
			run_d = (DIV_W+1)'(1);
			run_ok_d = 1'b1;
		end else if (div_live) begin
			run_d = (run_q == '1) ? run_q : run_q + 1'b1; // Saturates, never wraps
			run_ok_d = run_ok_q;
		end
	end

	// Divider check helper registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_age_q <= 2'h0;
			run_q <= '0;
			run_ok_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			div_age_q <= div_age_d;
			run_q <= run_d;
			run_ok_q <= run_ok_d;
			pin_prev_q <= pin_out;
		end
	end

	// Checks
	static_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == FN_LOW |=> !pin_out && pin_oe)
		else $error("static low code drove pin high");

	static_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == FN_HIGH |=> pin_out && pin_oe)
		else $error("static high code drove pin low");

	div_half_a: assert property (@(posedge pclk) disable iff (!presetn)
		div_live |-> (div_edge ? (!run_ok_q || run_q == (DIV_W+1)'(DIV_RATIO / 2))
		: run_q < (DIV_W+1)'(DIV_RATIO / 2)))
		else $error("divided clock half period is not sixteen cycles");

	wdog_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
		wdog_expire && func_q == FN_WDOG ##1 func_q == FN_WDOG && !wdog_expire
		##1 func_q == FN_WDOG |-> pin_out ##1 !pin_out)
		else $error("watchdog strobe not one cycle wide");

	mem_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == FN_MEM_RD |=> pin_out == $past(stat.mem_rd_busy))
		else $error("memory read status not mirrored");

	all_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == FN_ALL_LOCK |=> pin_out == ($past(stat.sm_lock)
		&& $past(stat.chan[0].phase_lock) && $past(stat.chan[0].an_lock)
		&& $past(stat.chan[1].phase_lock) && $past(stat.chan[1].an_lock)))
		else $error("combined lock output wrong");

	irq_any_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == FN_IRQ_ANY && (stat.irq_common || stat.irq_chan != '0) |=> pin_out)
		else $error("interrupt OR output missed a request");

	ref_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q[7:2] == FN_REF_FAULT_GRP |=>
		pin_out == $past(stat.refs[func_q[1:0]].fault))
		else $error("reference fault flag not shown");

	chan1_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == 8'hd6 |=> pin_out == $past(stat.chan[1].holdover))
		else $error("channel 1 holdover not shown");

	input_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		!func_q[DIR_BIT] |=> !pin_oe && !pin_out)
		else $error("pin driven while in input mode");

	unlisted_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		func_q == 8'h87 || func_q == 8'h8e |=> !pin_out)
		else $error("unlisted code drove pin high");

	irq_set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		wdog_expire && ien_q[IRQ_WDOG_BIT] && !(wr_en && paddr == ADDR_IEN)
		|=> irq && ists_q[IRQ_WDOG_BIT])
		else $error("watchdog event lost from interrupt");

endmodule // mfpm_top

// ==== mfpm_board.sv ====
// Board logic that shares the multifunction pin with the device
`timescale 1ns/1ps
module mfpm_board (
	input wire logic pclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic level,
	output logic pin_in,
	output logic seen_q
);
	// Wire level: device wins while it drives, else the board's own driver
	assign pin_in = pin_oe ? pin_out : level;
	// Board samples the pin on the same clock as the device
	always_ff @(posedge pclk) begin
		seen_q <= pin_in;
	end
endmodule // mfpm_board

// ==== multifunction_status_pin_mux_tb.sv ====
// Self-checking testbench of the multifunction status pin selector
`timescale 1ns/1ps
module multifunction_status_pin_mux_tb;
	import mfpm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdog_expire;
	logic pin_in, pin_out, pin_oe, irq, level, seen;
	logic [7:0] paddr, cur_code;
	logic [31:0] pwdata, prdata, r;
	mfpm_stat_t stat;
	int mismatches = 0, n_tests = 0, cyc = 0;
	logic [31:0] highs, rises;
	logic prev, err;

	mfpm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stat(stat), .wdog_expire(wdog_expire),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	mfpm_board u_board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.level(level), .pin_in(pin_in), .seen_q(seen));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Hang guard, well above the length of the sequence below
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("FAIL %s code %h expected %h got %h", n, cur_code, e, g);
			mismatches++;
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Source change shows on the pin one edge after it is driven
	task automatic setst(input logic [49:0] v, input logic e);
		@(posedge pclk);
		stat <= mfpm_stat_t'(v);
		@(posedge pclk);
		#1;
		chk("pin_out", {31'h0, e}, {31'h0, pin_out});
		chk("pin_oe", 32'h1, {31'h0, pin_oe});
	endtask

	// Stimuli: all low, all high, only the source, all but the source
	task automatic cc(input logic [7:0] c, input int idx, input logic [3:0] e);
		logic [49:0] oh;
		oh = 50'h1 << idx;
		cur_code = c;
		apb(1'b1, ADDR_FUNC, {24'h0, c});
		setst('0, e[3]);
		setst('1, e[2]);
		setst(oh, e[1]);
		setst(~oh, e[0]);
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, wdog_expire, level} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stat = '0;
		cur_code = 8'h00;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_FUNC, 32'h0);
		chk("func reset", 32'h0, r);
		apb(1'b0, ADDR_IEN, 32'h0);
		chk("ien reset", 32'h0, r);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("pin_oe idle", 32'h0, {31'h0, pin_oe});
		// Input direction: board edge raises the pin-in event
		@(posedge pclk);
		level <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, ADDR_ISTAT, 32'h0);
		chk("in event", 32'h1, {31'h0, r[IRQ_PIN_IN_BIT]});
		cc(8'h80, 0, 4'h0);
		cc(8'h81, 0, 4'hf);
		// Pin state register while driving high: out, synced in and enable all set
		apb(1'b0, ADDR_PIN, 32'h0);
		chk("pin state", 32'h7, r);
		for (int i = 0; i < 3; i++) cc(8'h84 + i, i, 4'h6);
		cc(8'h87, 0, 4'h0);
		cc(8'h8d, 0, 4'h0);
		cc(8'h88, 3, 4'h6);
		cc(8'h89, 4, 4'h6);
		cc(8'h8a, 3, 4'h4);
		cc(8'h8b, 21, 4'h4);
		cc(8'h8c, 34, 4'h4);
		cc(8'h90, 47, 4'h7);
		for (int i = 0; i < 3; i++) cc(8'h91 + i, 47 + i, 4'h6);
		for (int i = 0; i < 4; i++) begin
			cc(8'ha0 + i, 5 + 4 * i, 4'h6);
			cc(8'ha8 + i, 6 + 4 * i, 4'h6);
			cc(8'hb0 + i, 7 + 4 * i, 4'h7);
		end
		for (int i = 0; i < 13; i++) begin
			if (i != 4) cc(8'hc0 + i, 21 + i, 4'h6);
			if (i < 8) cc(8'hd0 + i, 34 + i, 4'h6);
		end
		cur_code = 8'h82;
		apb(1'b1, ADDR_FUNC, 32'h82);
		repeat (2) @(posedge pclk);
		#1;
		highs = 32'h0;
		rises = 32'h0;
		prev = pin_out;
		repeat (64) begin
			@(posedge pclk);
			#1;
			highs += {31'h0, pin_out};
			rises += {31'h0, pin_out && !prev};
			prev = pin_out;
		end
		chk("div highs", 32'd32, highs);
		chk("div rises", 32'd2, rises);
		cur_code = 8'h83;
		apb(1'b1, ADDR_FUNC, 32'h83);
		apb(1'b1, ADDR_IEN, 32'h1);
		apb(1'b1, ADDR_ICLR, 32'h7);
		@(posedge pclk);
		wdog_expire <= 1'b1;
		@(posedge pclk);
		wdog_expire <= 1'b0;
		highs = 32'h0;
		repeat (6) begin
			@(posedge pclk);
			#1;
			highs += {31'h0, pin_out};
		end
		chk("strobe len", STROBE_CYC, highs);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'b1, ADDR_IEN, 32'h0);
		// The enable write lands at the access edge; look once it has settled
		#1;
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, ADDR_ICLR, 32'h1);
		apb(1'b0, ADDR_ISTAT, 32'h0);
		chk("wdog cleared", 32'h0, {31'h0, r[IRQ_WDOG_BIT]});
		cur_code = 8'h00;
		apb(1'b1, ADDR_FUNC, 32'h0);
		repeat (2) @(posedge pclk);
		#1;
		chk("pin_oe input", 32'h0, {31'h0, pin_oe});
		// Released pin shows the board's own high level to the board's sampler
		chk("board seen", 32'h1, {31'h0, seen});
		give_verdict();
	end
endmodule // multifunction_status_pin_mux_tb
